// file: core/irq_ctrl_pkg.sv
// package: register map, field positions, reset values and carriers of the interrupt controller
package irq_ctrl_pkg;
    // register word offsets (word indices on the bus)
    localparam logic [3:0] OFF_IRQ_CONTROL = 4'h0;
    localparam logic [3:0] OFF_GROUP0_ENABLE = 4'h1;
    localparam logic [3:0] OFF_GROUP0_FLAG = 4'h2;
    localparam logic [3:0] OFF_PERIPH_ENABLE = 4'h3;
    localparam logic [3:0] OFF_PERIPH_FLAG = 4'h4;
    localparam logic [3:0] OFF_SHADOW_BASE = 4'h8;
    localparam int SHADOW_COUNT = 6;
    // shadow slot indices
    localparam int SH_W = 0;
    localparam int SH_STATUS = 1;
    localparam int SH_BANK = 2;
    localparam int SH_PTR_LO = 3;
    localparam int SH_PTR_HI = 4;
    localparam int SH_PC_HIGH = 5;
    // field positions
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_PERIPH_GROUP_EN = 6;
    localparam int BIT_EDGE_SEL = 0;
    localparam int BIT_TIMER0 = 5;
    localparam int BIT_PIN_CHANGE = 4;
    localparam int BIT_EXT_PIN = 0;
    localparam int BIT_WDT_EXPIRY = 4;
    localparam int BIT_SLEEP_ENTRY = 3;
    // implemented-bit and save masks, reset values and other constants
    localparam logic [7:0] CONTROL_MASK = 8'hC1;
    localparam logic [7:0] GROUP0_MASK = 8'h31;
    localparam logic [7:0] STATUS_SAVE_MASK = 8'hE7;
    localparam logic [7:0] CONTROL_RESET = 8'h01;
    localparam logic [7:0] GROUP0_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] VECTOR_ADDR = 16'h0004;
    localparam int PERIPH_SOURCES = 8;

    // cpu context carried into and out of the shadow set
    typedef struct packed {
        logic [7:0] w;
        logic [7:0] status;
        logic [7:0] bank;
        logic [7:0] ptr_lo;
        logic [7:0] ptr_hi;
        logic [7:0] pc_high;
    } cpu_context_t;

    // commands toward the cpu sequencer
    typedef struct packed {
        logic flush;
        logic push_pc;
        logic load_vector;
        logic restore;
        logic pop_pc;
    } seq_cmd_t;
endpackage

// file: core/cpu_interrupt_controller.sv
// interrupt controller: flags, enables, vector request, context shadows, sleep wake, pin edge
// Operation
// - reset clears all global, group, source enables
// - flags set by events regardless of enables
// - peripheral sources also need group enable
// - group-0 sources need only global enable
// - entry flushes, clears global, pushes, saves, vectors
// - disabled global holds requests pending until enabled
// - return pops, restores context, sets global enable
// - requests sampled in first quarter phase only
// - enabled source wakes sleep; vector if global
// - instruction after sleep executes before vector
// - external pin edge detected after three-stage clock sampling
// - edge select: one rising, zero falling; resets one
// - valid pin edge sets flag; vectors when enabled
// - entry saves context except two status flags
// - shadows readable and writable from bus
// - control register: global 7, group 6, edge 0
// - group-0 enables: timer0 5, change 4, pin 0
// - unimplemented bits read zero, ignore writes
//
// Register map (word index on the bus, data in byte lane 0)
//   0  control: global enable 7, group enable 6, edge select 0
//   1  group-0 enables: timer0 5, pin change 4, external pin 0
//   2  group-0 flags, same positions; a written zero clears a flag
//   3  peripheral enables, one bit per peripheral source
//   4  peripheral flags, one bit per peripheral source
//   8..13  shadow copies: w, status, bank, pointer low, pointer high,
//          program counter high latch
//   any other index reads zero and ignores writes
//
// Bus timing
//   a request is taken on the first edge that sees read or write while
//   no acknowledge is pending; waitrequest drops for the following cycle
//   and read data stand in that same cycle. The write lands at the taking
//   edge, so the register already shows it while waitrequest is low.
//   Back-to-back requests each cost one wait cycle.
//
// Sequencer handshake
//   requests are looked at only at an instruction boundary in the first
//   quarter phase; a taken request moves to the entry phase, whose cycle
//   emits flush, push and vector-load together, drops the global enable
//   and copies the live context into the shadows. A return pulse gives
//   pop and restore one cycle later, with the shadow context beside them.
//   The sequencer should not ask for a return in the cycle that an entry
//   is being sampled; the return has priority if it does.
//
// Sleep
//   a flagged and enabled source wakes the core even with the global
//   enable clear; peripheral sources also need their group enable and the
//   clockless mark, since a clocked peripheral cannot raise its flag in
//   sleep. Vectoring waits for the instruction after the sleep to finish.
//
// External pin
//   the pin crosses three flip-flops; a level counts once the second and
//   third stages agree, which filters a single-cycle glitch at the cost of
//   about four cycles of latency. The tracked level is loaded from the
//   synchroniser during the first cycles after reset so that a pin that
//   idles high does not show a false rising edge.
//
// Flags
//   hardware sets win over a software clear in the same cycle, so an event
//   that arrives while firmware acknowledges the previous one is not lost.
//   Firmware must clear what it served before returning, or the same
//   source is taken again straight away.
//
// Reset
//   every enable, flag and shadow clears; edge select comes back set;
//   waitrequest stands high and the command lines stay low until the
//   first request. Reset is synchronous, so it needs one clock edge.
//
// Peripheral sources
//   the group shares one byte of enables and one byte of flags; a narrower
//   group leaves the upper bits unimplemented, reading zero and ignoring
//   writes, exactly like the unused positions of the other registers.
//
// Limitations
//   only lane 0 of the bus carries data; the upper lanes read zero.
//   Entry latency beyond the sampling point belongs to the sequencer.
`timescale 1ns/1ps
module cpu_interrupt_controller
    import irq_ctrl_pkg::*;
#(
    parameter int N_PERIPH = irq_ctrl_pkg::PERIPH_SOURCES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // event sources
    input wire logic ext_pin,
    input wire logic timer0_overflow_evt,
    input wire logic pin_change_evt,
    input wire logic [N_PERIPH-1:0] periph_evt,
    input wire logic [N_PERIPH-1:0] periph_clockless,
    // cpu sequencer
    input wire logic first_quarter_phase,
    input wire logic instr_boundary,
    input wire logic return_from_isr_op,
    input wire logic in_sleep,
    input wire logic post_sleep_instr_done,
    input wire irq_ctrl_pkg::cpu_context_t cpu_context,
    output irq_ctrl_pkg::seq_cmd_t seq_cmd,
    output irq_ctrl_pkg::cpu_context_t restore_context,
    output logic [15:0] vector_addr,
    output logic wake,
    output logic global_irq_enable
);
    import irq_ctrl_pkg::*;

    // flag and enable registers are one byte wide, so more sources have no home
    if (N_PERIPH < 1 || N_PERIPH > 8) begin : g_bad_periph
        $error("N_PERIPH must be 1 to 8");
    end

    // entry takes its own cycle so the shadows see a settled context;
    // each step along run, entry, run and run, wake, run flips one bit
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_AFTER_WAKE = 2'b10,
        ST_ENTRY = 2'b01
    } phase_t;

    typedef struct packed {
        // sequencer phase and control bits
        phase_t phase;
        logic global_en;
        logic group_en;
        logic edge_sel;
        // enables and flags
        logic [7:0] group0_en;
        logic [7:0] group0_flag;
        logic [7:0] periph_en;
        logic [7:0] periph_flag;
        logic [SHADOW_COUNT-1:0][7:0] shadow;
        // external pin path
        logic [2:0] pin_sync;
        logic pin_level;
        logic [1:0] pin_warm;
        // bus answer
        logic ack;
        logic [31:0] rdata;
        // sequencer outputs
        seq_cmd_t cmd;
        cpu_context_t rst_ctx;
        logic wake;
    } state_t;

    state_t q;
    state_t d;

    // merges the enabled byte lanes of a byte register (lane 0 only holds data)
    function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [7:0] wd,
                                              input logic be, input logic [7:0] mask);
        lane_merge = be ? ((wd & mask) | (old & ~mask)) : old;
    endfunction

    function automatic logic [7:0] pad8(input logic [N_PERIPH-1:0] v);
        logic [7:0] r;
        r = BYTE_ZERO;
        r[N_PERIPH-1:0] = v;
        pad8 = r;
    endfunction

    // decoded helpers, all derived from the current state and inputs
    logic [7:0] periph_mask;
    logic [7:0] evt0;
    logic [7:0] evtp;
    logic pin_edge;
    logic group0_pending;
    logic periph_pending;
    logic irq_pending;
    logic wake_cond;
    logic wr;
    logic rd;

    always_comb begin
        periph_mask = pad8({N_PERIPH{1'b1}});
        wr = avs_write && !q.ack;
        rd = avs_read && !q.ack;
        // a change counts only once the second and third stages agree
        // no edge is reported until the synchroniser has filled after reset
        pin_edge = (q.pin_warm == 2'h3) && (q.pin_sync[2] == q.pin_sync[1])
                   && (q.pin_sync[1] != q.pin_level)
                   && (q.pin_sync[1] == q.edge_sel);
        // event pulses gathered into register positions
        evt0 = BYTE_ZERO;
        evt0[BIT_TIMER0] = timer0_overflow_evt;
        evt0[BIT_PIN_CHANGE] = pin_change_evt;
        evt0[BIT_EXT_PIN] = pin_edge;
        evtp = pad8(periph_evt);
        // group-0 sources bypass the group enable; peripheral ones do not
        group0_pending = |(q.group0_flag & q.group0_en);
        periph_pending = q.group_en && |(q.periph_flag & q.periph_en);
        irq_pending = q.global_en && (group0_pending || periph_pending);
        // sleep wake needs the source enables (peripherals also the group enable and clockless mark), not the global one
        wake_cond = |(q.group0_flag & q.group0_en)
                    || (q.group_en && |(q.periph_flag & q.periph_en & pad8(periph_clockless)));
    end

    // next state
    always_comb begin
        d = q;
        d.cmd = '0;
        d.wake = 1'b0;
        d.ack = 1'b0;
        d.rdata = 32'h0000_0000;
        d.pin_sync = {q.pin_sync[1:0], ext_pin};
        if (q.pin_sync[2] == q.pin_sync[1]) begin
            d.pin_level = q.pin_sync[1];
        end
        // while the synchroniser fills, the tracked level follows it silently
        if (q.pin_warm != 2'h3) begin
            d.pin_warm = q.pin_warm + 2'h1;
            d.pin_level = q.pin_sync[1];
        end
        // bus side: one wait cycle, then acknowledge
        // writes land at the taking edge; only implemented bits change
        // and a disabled byte lane leaves the register as it was
        if (wr) begin
            d.ack = 1'b1;
            unique case (avs_address)
                OFF_IRQ_CONTROL: begin
                    if (avs_byteenable[0]) begin
                        d.global_en = avs_writedata[BIT_GLOBAL_EN];
                        d.group_en = avs_writedata[BIT_PERIPH_GROUP_EN];
                        d.edge_sel = avs_writedata[BIT_EDGE_SEL];
                    end
                end
                OFF_GROUP0_ENABLE: d.group0_en = lane_merge(q.group0_en, avs_writedata[7:0],
                    avs_byteenable[0], GROUP0_MASK);
                OFF_GROUP0_FLAG: d.group0_flag = lane_merge(q.group0_flag, avs_writedata[7:0],
                    avs_byteenable[0], GROUP0_MASK);
                OFF_PERIPH_ENABLE: d.periph_en = lane_merge(q.periph_en, avs_writedata[7:0],
                    avs_byteenable[0], periph_mask);
                OFF_PERIPH_FLAG: d.periph_flag = lane_merge(q.periph_flag, avs_writedata[7:0],
                    avs_byteenable[0], periph_mask);
                default: begin
                    if (avs_address >= OFF_SHADOW_BASE
                        && avs_address < OFF_SHADOW_BASE + 4'(SHADOW_COUNT)) begin
                        d.shadow[3'(avs_address - OFF_SHADOW_BASE)] = lane_merge(
                            q.shadow[3'(avs_address - OFF_SHADOW_BASE)], avs_writedata[7:0],
                            avs_byteenable[0], 8'hFF);
                    end
                end
            endcase
        end
        // read data is registered now and stands in the acknowledge cycle;
        // unmapped indices keep the cleared default of zero
        if (rd) begin
            d.ack = 1'b1;
            unique case (avs_address)
                OFF_IRQ_CONTROL: d.rdata[7:0] = {q.global_en, q.group_en, 5'h00, q.edge_sel};
                OFF_GROUP0_ENABLE: d.rdata[7:0] = q.group0_en & GROUP0_MASK;
                OFF_GROUP0_FLAG: d.rdata[7:0] = q.group0_flag & GROUP0_MASK;
                OFF_PERIPH_ENABLE: d.rdata[7:0] = q.periph_en & periph_mask;
                OFF_PERIPH_FLAG: d.rdata[7:0] = q.periph_flag & periph_mask;
                default: begin
                    if (avs_address >= OFF_SHADOW_BASE
                        && avs_address < OFF_SHADOW_BASE + 4'(SHADOW_COUNT)) begin
                        d.rdata[7:0] = q.shadow[3'(avs_address - OFF_SHADOW_BASE)];
                    end
                end
            endcase
        end
        // events after software writes so a set in the clearing cycle wins
        d.group0_flag = d.group0_flag | (evt0 & GROUP0_MASK);
        d.periph_flag = d.periph_flag | (evtp & periph_mask);
        // sequencer
        unique case (q.phase)
            ST_RUN: begin
                // wake first, then return, then a new entry; an entry is never
                // sampled while the core sleeps, since the instruction after
                // the sleep must run before any vector
                if (in_sleep && wake_cond) begin
                    d.wake = 1'b1;
                    d.phase = ST_AFTER_WAKE;
                end else if (return_from_isr_op) begin
                    d.cmd.pop_pc = 1'b1;
                    d.cmd.restore = 1'b1;
                    d.rst_ctx = {q.shadow[SH_W], q.shadow[SH_STATUS], q.shadow[SH_BANK],
                                 q.shadow[SH_PTR_LO], q.shadow[SH_PTR_HI], q.shadow[SH_PC_HIGH]};
                    d.global_en = 1'b1;
                end else if (first_quarter_phase && instr_boundary && irq_pending
                             && !in_sleep) begin
                    d.phase = ST_ENTRY;
                end
            end
            ST_AFTER_WAKE: begin
                // the instruction after sleep must finish first
                if (post_sleep_instr_done) begin
                    d.phase = ST_RUN;
                end
            end
            ST_ENTRY: begin
                d.cmd.flush = 1'b1;
                d.cmd.push_pc = 1'b1;
                d.cmd.load_vector = 1'b1;
                d.global_en = 1'b0;
                d.shadow[SH_W] = cpu_context.w;
                // watchdog and sleep flags keep their shadow value
                d.shadow[SH_STATUS] = (cpu_context.status & STATUS_SAVE_MASK)
                                      | (q.shadow[SH_STATUS] & ~STATUS_SAVE_MASK);
                d.shadow[SH_BANK] = cpu_context.bank;
                // a bus write to a shadow in this very cycle is overwritten,
                // since the live context is what the return must bring back
                d.shadow[SH_PTR_LO] = cpu_context.ptr_lo;
                d.shadow[SH_PTR_HI] = cpu_context.ptr_hi;
                d.shadow[SH_PC_HIGH] = cpu_context.pc_high;
                d.phase = ST_RUN;
            end
            default: d.phase = ST_RUN;
        endcase
    end

    // state register; reset leaves every enable cleared
    // only constants are loaded in reset, so the branch needs no live input;
    // edge select is the one field whose reset value is one
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            q <= '0;
            q.edge_sel <= CONTROL_RESET[BIT_EDGE_SEL];
            q.group0_en <= GROUP0_RESET;
        end else begin
            q <= d;
        end
    end

    // outputs straight from state flip-flops, apart from the constant vector address
    // only an inverter on waitrequest sits between the flip-flops and the ports, so the sequencer
    // sees clean pulses with a full cycle of settling time
    always_comb begin
        avs_readdata = q.rdata;
        avs_waitrequest = !q.ack;
        seq_cmd = q.cmd;
        restore_context = q.rst_ctx;
        vector_addr = VECTOR_ADDR;
        wake = q.wake;
        global_irq_enable = q.global_en;
    end
endmodule

// file: tb/cpu_seq_model.sv
// partner model: cpu sequencer quarter phases, return requests and sleep
`timescale 1ns/1ps
module cpu_seq_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // firmware requests and controller wake
    input wire logic sleep_req,
    input wire logic ret_req,
    input wire logic wake,
    // sequencer lines
    output logic first_quarter_phase,
    output logic instr_boundary,
    output logic return_from_isr_op,
    output logic in_sleep,
    output logic post_sleep_instr_done
);
    logic [1:0] phase;
    logic woke;
    // four clocks per instruction, sampling point at its first quarter
    assign first_quarter_phase = (phase == 2'h0);
    assign instr_boundary = (phase == 2'h0);
    // phase keeps running in sleep so a late wake still finds a boundary
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            phase <= 2'h0;
            woke <= 1'b0;
            in_sleep <= 1'b0;
            return_from_isr_op <= 1'b0;
            post_sleep_instr_done <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            return_from_isr_op <= ret_req;
            in_sleep <= sleep_req | (in_sleep & ~wake);
            woke <= (woke | wake) & ~post_sleep_instr_done;
            post_sleep_instr_done <= woke & ~post_sleep_instr_done & (phase == 2'h3);
        end
    end
endmodule

// file: tb/cpu_interrupt_controller_chk.sv
// checker: bus answer, entry, return and wake timing at the controller ports
`timescale 1ns/1ps
module irq_ctrl_chk
    import irq_ctrl_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // watched ports
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic first_quarter_phase,
    input wire logic return_from_isr_op,
    input wire logic in_sleep,
    input wire irq_ctrl_pkg::seq_cmd_t seq_cmd,
    input wire logic wake,
    input wire logic global_irq_enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // entry and return each fire several sequencer commands at once
    sequence s_entry;
        seq_cmd.flush && seq_cmd.push_pc && seq_cmd.load_vector;
    endsequence
    sequence s_ret;
        seq_cmd.pop_pc && seq_cmd.restore;
    endsequence
    AST_RST_OFF: assert property ($past(reset) |-> !global_irq_enable)
        else $error("global enable set after reset");
    AST_ENTRY_CMDS: assert property (seq_cmd.flush |-> s_entry)
        else $error("entry commands split");
    AST_ENTRY_GIE: assert property (seq_cmd.flush
        |-> $past(global_irq_enable, 2) || $past(global_irq_enable, 3))
        else $error("entry without global enable");
    AST_ENTRY_Q1: assert property (seq_cmd.flush
        |-> $past(first_quarter_phase, 2) || $past(first_quarter_phase, 3))
        else $error("entry not sampled at first quarter");
    AST_RET: assert property (return_from_isr_op |-> ##[1:2] s_ret ##[0:1] global_irq_enable)
        else $error("return sequence missing");
    AST_WAKE: assert property (wake |-> $past(in_sleep))
        else $error("wake outside sleep");
    AST_NO_VEC_SLEEP: assert property (seq_cmd.flush |-> !in_sleep)
        else $error("vector taken while asleep");
    AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("acknowledge longer than one cycle");
    AST_ACK_CAUSE: assert property (!avs_waitrequest
        |-> $past(avs_read || avs_write) && avs_readdata[31:8] == 24'h000000)
        else $error("acknowledge without request or dirty upper bits");
endmodule
bind cpu_interrupt_controller irq_ctrl_chk i_irq_ctrl_chk (.sys_clk, .reset, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .first_quarter_phase, .return_from_isr_op,
    .in_sleep, .seq_cmd, .wake, .global_irq_enable);

// file: tb/tb.sv
// testbench: registers, flags, pin edges, entry, return, masking and wake
`timescale 1ns/1ps
module tb;
    import irq_ctrl_pkg::*;
    logic sys_clk, reset, avs_read, avs_write, avs_waitrequest, ext_pin, wake, t0, pc;
    logic first_quarter_phase, instr_boundary, return_from_isr_op, in_sleep, ret_req;
    logic post_sleep_instr_done, global_irq_enable, sleep_req;
    logic [3:0] avs_address;
    logic [15:0] vec;
    logic [31:0] avs_writedata, avs_readdata;
    logic [7:0] periph_evt, q, w_back;
    seq_cmd_t seq_cmd;
    cpu_context_t cpu_context, restore_context;
    int err_count, n_checks, n_entry, n_wake;
    // address, write value, value read back
    logic [19:0] rows [8] = '{20'h0FFC1, 20'h04040, 20'h1FF31, 20'h10000, 20'h7FF00,
        20'h85A5A, 20'h91818, 20'hDC3C3};
    cpu_interrupt_controller i_cpu_interrupt_controller (.sys_clk, .reset, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
        .avs_waitrequest, .ext_pin, .timer0_overflow_evt(t0), .pin_change_evt(pc),
        .periph_evt, .periph_clockless(8'h01), .first_quarter_phase, .instr_boundary,
        .return_from_isr_op, .in_sleep, .post_sleep_instr_done, .cpu_context,
        .seq_cmd, .restore_context, .vector_addr(vec), .wake, .global_irq_enable);
    cpu_seq_model i_cpu_seq_model (.sys_clk, .reset, .sleep_req, .ret_req, .wake,
        .first_quarter_phase, .instr_boundary, .return_from_isr_op, .in_sleep,
        .post_sleep_instr_done);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // request held until waitrequest is sampled low; only the watchdog ends a hang
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge sys_clk);
        end
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [3:0] a);
        bus(1'b0, a, 8'h00);
    endtask
    // one-cycle event: 0 timer0, 1 peripheral 0, 2 pin change
    task automatic evt(input int k);
        @(posedge sys_clk);
        {pc, periph_evt[0], t0} <= 3'(1 << k);
        @(posedge sys_clk);
        {pc, periph_evt[0], t0} <= 3'h0;
    endtask
    task automatic pin(input logic v, input logic [7:0] e);
        @(posedge sys_clk);
        ext_pin <= v;
        idle(10);
        rd(4'h2);
        chk(q, e, "pin flag");
        wr(4'h2, 8'h00);
    endtask
    // firmware clears every flag before returning, else the same source re-enters
    task automatic leave();
        wr(4'h2, 8'h00);
        wr(4'h4, 8'h00);
        @(posedge sys_clk);
        ret_req <= 1'b1;
        @(posedge sys_clk);
        ret_req <= 1'b0;
        idle(8);
    endtask
    task automatic finish_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // run needs about three hundred cycles
    initial begin
        #100000;
        err_count++;
        finish_test();
    end
    always @(posedge sys_clk) begin
        n_entry += int'(seq_cmd.flush === 1'b1);
        n_wake += int'(wake === 1'b1);
        if (seq_cmd.restore === 1'b1) w_back <= restore_context.w;
    end
    initial begin
        {reset, avs_read, avs_write, ext_pin, t0, pc, sleep_req, ret_req} = 8'h80;
        avs_address = 4'h0;
        avs_writedata = 32'h00000000;
        periph_evt = 8'h00;
        cpu_context = 48'hA5E03C123456;
        idle(16);
        reset <= 1'b0;
        rd(4'h0);
        chk(q, CONTROL_RESET, "control reset");
        foreach (rows[i]) begin
            wr(rows[i][19:16], rows[i][15:8]);
            rd(rows[i][19:16]);
            chk(q, rows[i][7:0], "register");
        end
        wr(4'h0, 8'h00);
        evt(0);
        evt(2);
        rd(4'h2);
        chk(q, 8'h30, "flags");
        wr(4'h2, 8'h00);
        pin(1'b1, 8'h00);
        pin(1'b0, 8'h01);
        wr(4'h0, 8'h01);
        pin(1'b1, 8'h01);
        wr(4'h1, 8'h20);
        wr(4'h0, 8'h80);
        evt(0);
        idle(12);
        chk(16'(n_entry), 16'h0001, "entry");
        chk(global_irq_enable, 1'b0, "global in isr");
        chk(vec, VECTOR_ADDR, "vector");
        rd(4'h9);
        chk(q, 8'hF8, "status shadow");
        rd(4'h8);
        chk(q, 8'hA5, "w shadow");
        wr(4'h8, 8'h77);
        leave();
        chk(w_back, 8'h77, "restored w");
        chk(global_irq_enable, 1'b1, "global after return");
        chk(16'(n_entry), 16'h0001, "no repeat");
        wr(4'h0, 8'h00);
        evt(0);
        idle(12);
        chk(16'(n_entry), 16'h0001, "masked");
        wr(4'h0, 8'h80);
        idle(12);
        chk(16'(n_entry), 16'h0002, "pending taken");
        leave();
        wr(4'h1, 8'h00);
        wr(4'h3, 8'h01);
        evt(1);
        idle(12);
        chk(16'(n_entry), 16'h0002, "group off");
        wr(4'h0, 8'hC0);
        idle(12);
        chk(16'(n_entry), 16'h0003, "group on");
        leave();
        // group on, global off: the peripheral source may wake but not vector
        wr(4'h0, 8'h40);
        @(posedge sys_clk);
        sleep_req <= 1'b1;
        @(posedge sys_clk);
        sleep_req <= 1'b0;
        evt(1);
        idle(12);
        chk(16'(n_wake > 0), 16'h0001, "wake");
        chk(16'(n_entry), 16'h0003, "no vector");
        reset <= 1'b1;
        idle(2);
        reset <= 1'b0;
        rd(4'h0);
        chk(q, CONTROL_RESET, "control after reset");
        finish_test();
    end
endmodule
